// File: ttl_channel.sv
// One TTL input: synchroniser, control type decode and pulse width check
`timescale 1ns/1ps
`default_nettype none
module ttl_channel (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  input wire logic [1:0] ctrl_type,
  input wire logic two_state,
  input wire logic ms_tick,
  output logic sync_level,
  output logic on_pulse,
  output logic off_pulse,
  output logic level
);

  logic s1_q, s2_q, s3_q;
  logic filt_q, filt_d;
  logic act_prev_q;
  logic [ttl_decode_pkg::PULSE_CNT_W-1:0] cnt_q, cnt_d;
  logic fired_q, fired_d;
  logic on_q, on_d, off_q, off_d, lvl_q, lvl_d;

  // Change accepted once second and third stages agree
  assign filt_d = (s2_q == s3_q) ? s3_q : filt_q;

  wire is_inv = (ctrl_type == ttl_decode_pkg::INVERTED_EDGE) ||
                (ctrl_type == ttl_decode_pkg::INVERTED_PULSE);
  wire is_pulse = ctrl_type[1];
  // Active level: low for normal types, high for inverted
  wire act = is_inv ? filt_q : ~filt_q;
  wire act_rise = act & ~act_prev_q;
  wire act_fall = ~act & act_prev_q;
  wire limit_hit = (cnt_q >= ttl_decode_pkg::PULSE_CNT_W'(ttl_decode_pkg::PULSE_LIMIT_TICKS));

  // Width counted in millisecond ticks while active
  assign cnt_d = !act ? '0 : (ms_tick && !limit_hit) ? cnt_q + 1'b1 : cnt_q;
  assign fired_d = act & (fired_q | (is_pulse & limit_hit));

  // Edge types: active edge on, other edge off only when two-state
  // Pulse types: on once the width limit is reached, trailing edge ignored
  assign on_d = is_pulse ? (act & limit_hit & ~fired_q) : act_rise;
  assign off_d = ~is_pulse & act_fall & two_state;
  // Level follows the active level for two-state actions on edge types only
  assign lvl_d = ~is_pulse & act & two_state;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= ttl_decode_pkg::PIN_RST;
      s2_q <= ttl_decode_pkg::PIN_RST;
      s3_q <= ttl_decode_pkg::PIN_RST;
      filt_q <= ttl_decode_pkg::PIN_RST;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_prev_q <= 1'b0;
      cnt_q <= '0;
      fired_q <= 1'b0;
      on_q <= 1'b0;
      off_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      act_prev_q <= act;
      cnt_q <= cnt_d;
      fired_q <= fired_d;
      on_q <= on_d;
      off_q <= off_d;
      lvl_q <= lvl_d;
    end
  end

  assign sync_level = filt_q;
  assign on_pulse = on_q;
  assign off_pulse = off_q;
  assign level = lvl_q;

endmodule : ttl_channel
`default_nettype wire

// File: ttl_decode_pkg.sv
// Shared constants for the TTL input action decoder
package ttl_decode_pkg;

  // Channel count and field widths
  localparam int NUM_IN = 8;
  localparam int TYPE_W = 2;
  localparam int ACT_W = 3;

  // Register byte offsets
  localparam logic [7:0] TYPE_OFF = 8'h00;
  localparam logic [7:0] ACTION_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] EVENT_OFF = 8'h0c;

  // Field positions
  localparam int STAT_LEVEL_POS = 8;
  localparam int EVT_OFF_POS = 8;

  // Reset values
  localparam logic [15:0] TYPE_RST = 16'h0000;
  localparam logic [23:0] ACTION_RST = 24'h000000;
  localparam logic PIN_RST = 1'b1;

  // Control types
  typedef enum logic [1:0] {
    NORMAL_EDGE = 2'h0,
    INVERTED_EDGE = 2'h1,
    NORMAL_PULSE = 2'h2,
    INVERTED_PULSE = 2'h3
  } ctrl_type_e;

  // Actions; codes below TWO_STATE_LIMIT have both an on and an off state
  localparam logic [2:0] ACT_BYPASS = 3'h0;
  localparam logic [2:0] ACT_PANEL_LIGHT = 3'h1;
  localparam logic [2:0] ACT_RELAY_OUT = 3'h2;
  localparam logic [2:0] ACT_SHUTDOWN = 3'h3;
  localparam logic [2:0] ACT_STANDBY = 3'h4;
  localparam logic [2:0] TWO_STATE_LIMIT = 3'h3;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DETECT_MS = 50;
  localparam int REJECT_MS = 4;
  // A pulse of REJECT_MS can straddle at most REJECT_MS+1 ticks; one of
  // DETECT_MS sees at least DETECT_MS-1; pick a limit safely in between.
  localparam int PULSE_LIMIT_TICKS = REJECT_MS + 6;
  localparam int PULSE_CNT_W = 6;

endpackage : ttl_decode_pkg

// File: ttl_input_action_decoder.sv
// Top of the TTL input action decoder with its AHB-Lite register slave
//
// Functional notes
// - Four control types per input, selectable.
// - Reset default is normal edge.
// - Normal edge: falling edge turns action on.
// - Rising edge turns two-state action off.
// - Rising edge ignored for single-state actions.
// - Bypass, light, relay held while input low.
// - Shutdown, standby not cancelled by release.
// - Inverted edge swaps rising and falling roles.
// - Normal pulse: falling active, rising ignored.
// - Pulses of 50 ms or more detected.
// - Pulses of 4 ms or less rejected.
// - Inverted pulse: rising active, high width measured.
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module ttl_input_action_decoder #(
  parameter int TICK_CYC = ttl_decode_pkg::TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] ttl_in,
  output logic [7:0] act_on,
  output logic [7:0] act_off,
  output logic [7:0] act_level
);

  localparam int N = ttl_decode_pkg::NUM_IN;

  // Millisecond tick
  logic [15:0] tick_cnt_q, tick_cnt_d;
  logic tick_q;
  wire tick_wrap = (tick_cnt_q == 16'(TICK_CYC - 1));
  assign tick_cnt_d = tick_wrap ? 16'h0000 : tick_cnt_q + 16'h0001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_wrap;
    end
  end

  // Register state
  logic [15:0] type_q, type_d;
  logic [23:0] action_q, action_d;
  logic [7:0] on_evt_q, on_evt_d;
  logic [7:0] off_evt_q, off_evt_d;

  // Channel outputs
  logic [N-1:0] sync_lvl;
  logic [N-1:0] on_s;
  logic [N-1:0] off_s;
  logic [N-1:0] lvl_s;
  logic [N-1:0] two_state;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      // Two-state actions are bypass, panel light and relay out
      assign two_state[g] = action_q[g*3 +: 3] < ttl_decode_pkg::TWO_STATE_LIMIT;
      ttl_channel u_ch (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(ttl_in[g]),
        .ctrl_type(type_q[g*2 +: 2]),
        .two_state(two_state[g]),
        .ms_tick(tick_q),
        .sync_level(sync_lvl[g]),
        .on_pulse(on_s[g]),
        .off_pulse(off_s[g]),
        .level(lvl_s[g])
      );
    end
  endgenerate

  // Address phase capture
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  wire addr_phase = hsel & htrans[1] & hready;
  wire [7:0] a_off = {haddr[7:2], 2'b00};
  wire a_hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
  wire rd_go = addr_phase & ~hwrite;

  // Data phase write decode
  wire wr_type = wr_pend_q && (wr_addr_q == ttl_decode_pkg::TYPE_OFF);
  wire wr_action = wr_pend_q && (wr_addr_q == ttl_decode_pkg::ACTION_OFF);
  wire wr_event = wr_pend_q && (wr_addr_q == ttl_decode_pkg::EVENT_OFF);

  assign type_d = wr_type ? hwdata[15:0] : type_q;
  assign action_d = wr_action ? hwdata[23:0] : action_q;
  // Write one to clear; a new event in the same cycle wins
  assign on_evt_d = (on_evt_q & ~(wr_event ? hwdata[7:0] : 8'h00)) | on_s;
  assign off_evt_d = (off_evt_q & ~(wr_event ? hwdata[15:8] : 8'h00)) | off_s;

  // Read mux
  wire [31:0] rd_type = {16'h0000, type_q};
  wire [31:0] rd_action = {8'h00, action_q};
  wire [31:0] rd_status = {16'h0000, lvl_s, sync_lvl};
  wire [31:0] rd_event = {16'h0000, off_evt_q, on_evt_q};
  wire [31:0] rd_mux =
    !a_hit ? 32'h00000000 :
    (a_off == ttl_decode_pkg::TYPE_OFF) ? rd_type :
    (a_off == ttl_decode_pkg::ACTION_OFF) ? rd_action :
    (a_off == ttl_decode_pkg::STATUS_OFF) ? rd_status :
    (a_off == ttl_decode_pkg::EVENT_OFF) ? rd_event : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= addr_phase & hwrite & a_hit;
      wr_addr_q <= a_off;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_go) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      type_q <= ttl_decode_pkg::TYPE_RST;
      action_q <= ttl_decode_pkg::ACTION_RST;
      on_evt_q <= 8'h00;
      off_evt_q <= 8'h00;
    end else begin
      type_q <= type_d;
      action_q <= action_d;
      on_evt_q <= on_evt_d;
      off_evt_q <= off_evt_d;
    end
  end

  // Strobes and levels to the action logic, one stage out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_on <= 8'h00;
      act_off <= 8'h00;
      act_level <= 8'h00;
    end else begin
      act_on <= on_s;
      act_off <= off_s;
      act_level <= lvl_s;
    end
  end

endmodule : ttl_input_action_decoder
`default_nettype wire

// File: ttl_input_action_decoder_asserts.sv
// Port checker for the TTL input action decoder
`timescale 1ns/1ps
`default_nettype none
module ttl_input_action_decoder_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [7:0] act_on,
  input wire logic [7:0] act_off,
  input wire logic [7:0] act_level
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_addr;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  AST_STROBE_EXCL: assert property ((act_on & act_off) == 8'h00)
    else $error("on and off strobe together");
  AST_ON_SINGLE: assert property ((act_on & $past(act_on)) == 8'h00)
    else $error("on strobe longer than one cycle");
  AST_OFF_SINGLE: assert property ((act_off & $past(act_off)) == 8'h00)
    else $error("off strobe longer than one cycle");
  AST_LEVEL_SET: assert property ((act_level & ~$past(act_level) & ~act_on) == 8'h00)
    else $error("level rose without on strobe");
  AST_LEVEL_CLR: assert property ((~act_level & $past(act_level) & ~act_off) == 8'h00)
    else $error("level fell without off strobe");
  AST_READ_STANDS: assert property (!$stable(hrdata) |-> $past(hsel && htrans[1] && !hwrite))
    else $error("read data changed outside a read");
  AST_ZERO_WAIT: assert property (rd_addr |=> hreadyout [*2])
    else $error("wait state inserted");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("error response");
endmodule : ttl_input_action_decoder_asserts
bind ttl_input_action_decoder ttl_input_action_decoder_asserts i_chk (.hclk, .hresetn, .hsel,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .act_on, .act_off, .act_level);
`default_nettype wire

// File: ttl_input_action_decoder_test.sv
// Self-checking bench for the TTL input action decoder
`timescale 1ns/1ps
`default_nettype none
module ttl_input_action_decoder_test;
  localparam int TK = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] ttl_in;
  logic [7:0] act_on;
  logic [7:0] act_off;
  logic [7:0] act_level;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 3435;
  int on_n[8];
  int off_n[8];
  always #50 hclk = ~hclk;
  ttl_input_action_decoder #(.TICK_CYC(TK)) i_dut (.hclk, .hresetn, .hsel(1'b1), .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ttl_in, .act_on, .act_off, .act_level);
  ttl_source i_src (.hclk, .ttl_in);
  always @(posedge hclk) begin
    for (int i = 0; i < 8; i++) begin
      on_n[i] += int'(act_on[i]);
      off_n[i] += int'(act_off[i]);
    end
  end
  function automatic logic [31:0] exp_on(input logic [1:0] t);
    return t < 2 ? 32'h2 : 32'h1;
  endfunction : exp_on
  function automatic logic [31:0] exp_lvl(input logic [1:0] t, input logic [2:0] a);
    return (t < 2 && a < 3) ? 32'h1 : 32'h0;
  endfunction : exp_lvl
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic complete_run;
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    logic [31:0] rd;
    logic [31:0] tv;
    logic [31:0] av;
    logic [1:0] t;
    logic [2:0] a;
    int b0;
    int f0;
    tv = 32'h0;
    av = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h00, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, 8'h10, 32'hffffffff, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    for (int k = 0; k < 8; k++) begin
      t = 2'(k);
      a = k < 5 ? 3'(k) : 3'($unsigned($random(seed)) % 5);
      tv = tv | (32'(t) << (2 * k));
      av = av | (32'(a) << (3 * k));
      bus(1'b1, 8'h04, av, rd);
      bus(1'b1, 8'h00, tv, rd);
      bus(1'b0, 8'h00, 32'h0, rd);
      check(rd, tv);
      i_src.set(k, !t[0]);
      repeat (300) @(posedge hclk);
      b0 = on_n[k];
      f0 = off_n[k];
      bus(1'b0, 8'h08, 32'h0, rd);
      check({31'h0, rd[k]}, {31'h0, !t[0]});
      i_src.set(k, t[0]);
      repeat (4 * TK) @(posedge hclk);
      i_src.set(k, !t[0]);
      repeat (300) @(posedge hclk);
      check(32'(on_n[k] - b0), exp_on(t) - 32'h1);
      i_src.set(k, t[0]);
      repeat (25 * TK) @(posedge hclk);
      check({31'h0, act_level[k]}, exp_lvl(t, a));
      repeat (25 * TK) @(posedge hclk);
      i_src.set(k, !t[0]);
      repeat (300) @(posedge hclk);
      check(32'(on_n[k] - b0), exp_on(t));
      check(32'(off_n[k] - f0), exp_lvl(t, a) << 1);
      check({31'h0, act_level[k]}, 32'h0);
    end
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge hclk);
    err_count++;
    complete_run();
  end
endmodule : ttl_input_action_decoder_test
`default_nettype wire

// File: ttl_source.sv
// Model of the external controller driving the TTL pins
`timescale 1ns/1ps
`default_nettype none
module ttl_source (
  input wire logic hclk,
  output logic [7:0] ttl_in
);
  initial ttl_in = 8'hff;
  // Drives one pin, called right after a clock edge
  task automatic set(input int ch, input logic v);
    ttl_in[ch] <= v;
  endtask : set
endmodule : ttl_source
`default_nettype wire
